/* File: apc_pkg.sv */
package apc_pkg;
    typedef enum logic [1:0] {
        RUN_HARD_MUTE = 2'h0,
        RUN_INIT      = 2'h1,
        RUN_START     = 2'h2,
        RUN_ACTIVE    = 2'h3
    } apc_run_t;
    typedef enum logic [2:0] {
        I2C_IDLE = 3'h0,
        I2C_DEV  = 3'h1,
        I2C_SUB  = 3'h2,
        I2C_WR   = 3'h3,
        I2C_RD   = 3'h4
    } apc_i2c_t;
    localparam logic [1:0] FMT_LJ  = 2'h0;
    localparam logic [1:0] FMT_RJ  = 2'h1;
    localparam logic [1:0] FMT_I2S = 2'h2;
    localparam logic [7:0] REG_GEN_STATUS = 8'h01;
    localparam logic [7:0] REG_ERR_STATUS = 8'h02;
    localparam logic [7:0] REG_SYS_CTRL1  = 8'h03;
    localparam logic [7:0] REG_PORT_CFG   = 8'h04;
    localparam logic [7:0] REG_MASTER_VOL = 8'h05;
    localparam logic [7:0] REG_PWM_CFG    = 8'h06;
    localparam logic [7:0] REG_AM_TUNE    = 8'h07;
    localparam int HPF_BIT        = 7;
    localparam int CFG_MASTER_BIT = 6;
    localparam int CFG_IN5_BIT    = 7;
    localparam int PWM_SIX_BIT    = 3;
    localparam int PWM_LOUT_BIT   = 4;
    localparam int PWM_F441_BIT   = 5;
    localparam int PWM_I192_BIT   = 6;
    localparam int PWM_AM_BIT     = 7;
    localparam logic       HPF_RST      = 1'b1;
    localparam logic [7:0] PORT_CFG_RST = 8'h0A;
    localparam logic [7:0] PWM_CFG_RST  = 8'h03;
    localparam logic [7:0] AM_TUNE_RST  = 8'h00;
    localparam logic [7:0] MVOL_MUTE    = 8'hFF;
    localparam logic [7:0] DUTY_MID     = 8'h80;
    localparam logic [7:0] PWM_TOP      = 8'hFF;
    localparam logic [5:0] WL_16 = 6'h10;
    localparam logic [5:0] WL_20 = 6'h14;
    localparam logic [5:0] WL_24 = 6'h18;
    localparam logic [4:0] WORD_MSB = 5'h17;
    localparam logic [3:0] OVS_8 = 4'h8;
    localparam logic [3:0] OVS_4 = 4'h4;
    localparam logic [3:0] OVS_2 = 4'h2;
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int BCLK_PER_FRAME = 64;
    localparam int FS_441K = 44_100;
    localparam int FS_48K = 48_000;
    localparam int FS_96K = 96_000;
    localparam int FS_192K = 192_000;
    localparam logic [4:0] HALF_441 = 5'(CLK_HZ / (FS_441K * BCLK_PER_FRAME * 2));
    localparam logic [4:0] HALF_48 = 5'(CLK_HZ / (FS_48K * BCLK_PER_FRAME * 2));
    localparam logic [4:0] HALF_96 = 5'(CLK_HZ / (FS_96K * BCLK_PER_FRAME * 2));
    localparam logic [4:0] HALF_192 = 5'(CLK_HZ / (FS_192K * BCLK_PER_FRAME * 2));
    localparam int INIT_TIME_US = 50;
    localparam int START_TIME_US = 20;
endpackage

/* File: apc_top.sv */
`timescale 1ns/1ps
// Function
// - Output framing is LJ, RJ or I2S only
// - Output words are 16, 20 or 24 bits
// - Input five only in master, own clocks
// - Input five active: no data, fast frame
// - Data output in use: 44.1/48 kHz frame
// - Bit clock is always 64 frame clocks
// - Master clock divider 4/2/1, default one
// - PWM takes 32-bit samples, eight channels
// - Eight drivers or six plus line-out
// - Headphone uses channels 1-2, exclusive
// - Oversampling 8x, 4x at 96k, 2x at 192k
// - Modulation limit 87.5 to 99.2 percent
// - High-pass enable bit, on by default
// - AM avoidance shifts the PWM rate
// - Any error-status write clears the clip, same-cycle clip wins
// - General status returns identification code
// - Reset pin mutes at once, no clock
// - Reset pin: outputs low, data undriven
// - Reset pin: ignore bus and audio
// - Release: defaults, init, quiet start
// - Stay muted until volume unmuted
module apc_top #(
    parameter int         INIT_CYCLES  = apc_pkg::INIT_TIME_US * apc_pkg::CLK_MHZ,
    parameter int         START_CYCLES = apc_pkg::START_TIME_US * apc_pkg::CLK_MHZ,
    parameter logic [6:0] DEV_ADDR     = 7'h1B,
    parameter logic [7:0] IDENT        = 8'h5A  // Arbitrary value
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        reset_pin_n,
    input  wire logic        scl,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_drive_n,
    input  wire logic        direct_serial_input_five,
    input  wire logic [23:0] tx_left,
    input  wire logic [23:0] tx_right,
    output logic             tx_load,
    output logic             frame_clock_output,
    output logic             bit_clock_output,
    output logic             serial_data_output,
    output logic             master_clock_output,
    output logic [23:0]      in5_left,
    output logic [23:0]      in5_right,
    output logic             in5_valid,
    input  wire logic [31:0] pcm_data,
    input  wire logic [2:0]  pcm_chan,
    input  wire logic        pcm_valid,
    input  wire logic        headphone_select_pin,
    output logic [7:0]       pwm_p,
    output logic [7:0]       pwm_m,
    output logic [1:0]       hp_p,
    output logic [1:0]       hp_m,
    output logic             valid,
    output logic             hpf_enable,
    output logic [3:0]       oversample
);
    if (INIT_CYCLES < 1 || INIT_CYCLES > 1_000_000 ||
        START_CYCLES < 1 || START_CYCLES > 1_000_000) begin : g_chk
        $error("apc_top: start-up counts out of range");
    end
    localparam logic [19:0] INIT_LAST = 20'(INIT_CYCLES - 1);
    localparam logic [19:0] START_LAST = 20'(START_CYCLES - 1);

    function automatic logic [5:0] wl_bits(input logic [1:0] c);
        return c == 2'h0 ? apc_pkg::WL_16 :
               c == 2'h1 ? apc_pkg::WL_20 : apc_pkg::WL_24;
    endfunction
    // Returns {in_word, bit index from MSB} for slot position p
    function automatic logic [5:0] slot_k(input logic [1:0] f,
                                          input logic [1:0] wc,
                                          input logic [4:0] p);
        logic [6:0] off;
        logic [6:0] k;
        off = f == apc_pkg::FMT_I2S ? 7'h01 :
              f == apc_pkg::FMT_RJ ? 7'h20 - {1'b0, wl_bits(wc)} : 7'h00;
        k = {2'h0, p} - off;  // Negative wraps high and fails the test
        return {k < {1'b0, wl_bits(wc)}, k[4:0]};
    endfunction

    // Register bus, ignored while the reset pin is low
    logic clr;
    assign clr = reset | ~reset_pin_n;
    apc_pkg::apc_i2c_t i2c_q, i2c_d;
    logic [3:0] bitn_q, bitn_d;
    logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d, rd_byte;
    logic       drv_q, drv_d, scl_q, sda_q, wr_en;
    logic       scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl & ~scl_q;
    assign scl_fall = ~scl & scl_q;
    assign start_c = scl & scl_q & sda_q & ~sda_in;
    assign stop_c = scl & scl_q & ~sda_q & sda_in;

    always_comb begin
        i2c_d = i2c_q;
        bitn_d = bitn_q;
        sh_d = sh_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        drv_d = drv_q;
        wr_en = 1'b0;
        if (start_c) begin
            i2c_d = apc_pkg::I2C_DEV;
            bitn_d = 4'h0;
            drv_d = 1'b0;
        end else if (stop_c) begin
            i2c_d = apc_pkg::I2C_IDLE;
            drv_d = 1'b0;
        end else if (i2c_q != apc_pkg::I2C_IDLE && scl_rise) begin
            if (bitn_q < 4'h8) begin
                sh_d = {sh_q[6:0], sda_in};
                bitn_d = bitn_q + 4'h1;
            end else if (i2c_q == apc_pkg::I2C_RD && sda_in) begin
                i2c_d = apc_pkg::I2C_IDLE;  // Master refused more data
            end
        end else if (i2c_q != apc_pkg::I2C_IDLE && scl_fall) begin
            if (bitn_q == 4'h8) begin
                bitn_d = 4'h9;
                drv_d = 1'b1;
                case (i2c_q)
                    apc_pkg::I2C_DEV: begin
                        if (sh_q[7:1] != DEV_ADDR) begin
                            i2c_d = apc_pkg::I2C_IDLE;
                            drv_d = 1'b0;
                        end else if (sh_q[0]) begin
                            i2c_d = apc_pkg::I2C_RD;
                        end else begin
                            i2c_d = apc_pkg::I2C_SUB;
                        end
                    end
                    apc_pkg::I2C_SUB: begin
                        ptr_d = sh_q;
                        i2c_d = apc_pkg::I2C_WR;
                    end
                    apc_pkg::I2C_WR: begin
                        wr_en = 1'b1;
                        ptr_d = ptr_q + 8'h01;
                    end
                    default: drv_d = 1'b0;
                endcase
            end else if (bitn_q == 4'h9) begin
                bitn_d = 4'h0;
                drv_d = 1'b0;
                if (i2c_q == apc_pkg::I2C_RD) begin
                    tx_d = rd_byte;
                    ptr_d = ptr_q + 8'h01;
                    drv_d = ~rd_byte[7];
                end
            end else if (i2c_q == apc_pkg::I2C_RD) begin
                drv_d = ~tx_q[3'h7 - bitn_q[2:0]];
            end
        end
    end
    always_ff @(posedge mclk) begin
        scl_q <= scl;
        sda_q <= sda_in;
        if (clr) begin
            i2c_q <= apc_pkg::I2C_IDLE;
            bitn_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            drv_q <= 1'b0;
        end else begin
            i2c_q <= i2c_d;
            bitn_q <= bitn_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            drv_q <= drv_d;
        end
    end
    assign sda_out = 1'b0;
    assign sda_drive_n = ~(drv_q & reset_pin_n);

    // Control and status registers
    logic       hpf_q, hpf_d, clip_q, clip_d, clip_set;
    logic [7:0] cfg_q, cfg_d, mvol_q, mvol_d, pwc_q, pwc_d, am_q, am_d;
    apc_pkg::apc_run_t run_q, run_d;
    always_comb begin
        case (ptr_q)
            apc_pkg::REG_GEN_STATUS: rd_byte = IDENT;
            apc_pkg::REG_ERR_STATUS: rd_byte = {6'h00, valid, clip_q};
            apc_pkg::REG_SYS_CTRL1:  rd_byte = {hpf_q, 7'h00};
            apc_pkg::REG_PORT_CFG:   rd_byte = cfg_q;
            apc_pkg::REG_MASTER_VOL: rd_byte = mvol_q;
            apc_pkg::REG_PWM_CFG:    rd_byte = pwc_q;
            apc_pkg::REG_AM_TUNE:    rd_byte = am_q;
            default:                 rd_byte = 8'h00;
        endcase
    end
    always_comb begin
        hpf_d = hpf_q;
        cfg_d = cfg_q;
        mvol_d = mvol_q;
        pwc_d = pwc_q;
        am_d = am_q;
        clip_d = clip_q;
        if (wr_en) begin
            case (ptr_q)
                apc_pkg::REG_ERR_STATUS: clip_d = 1'b0;
                apc_pkg::REG_SYS_CTRL1:  hpf_d = sh_q[apc_pkg::HPF_BIT];
                apc_pkg::REG_PORT_CFG:   cfg_d = sh_q;
                apc_pkg::REG_MASTER_VOL: mvol_d = sh_q;
                apc_pkg::REG_PWM_CFG:    pwc_d = sh_q;
                apc_pkg::REG_AM_TUNE:    am_d = sh_q;
                default:                 clip_d = clip_q;
            endcase
        end
        if (clip_set) begin
            clip_d = 1'b1;  // A new clip outranks a clearing write
        end
    end
    always_ff @(posedge mclk) begin
        if (clr) begin
            hpf_q <= apc_pkg::HPF_RST;
            cfg_q <= apc_pkg::PORT_CFG_RST;
            mvol_q <= apc_pkg::MVOL_MUTE;
            pwc_q <= apc_pkg::PWM_CFG_RST;
            am_q <= apc_pkg::AM_TUNE_RST;
            clip_q <= 1'b0;
        end else begin
            hpf_q <= hpf_d;
            cfg_q <= cfg_d;
            mvol_q <= mvol_d;
            pwc_q <= pwc_d;
            am_q <= am_d;
            clip_q <= clip_d;
        end
    end
    assign hpf_enable = hpf_q;

    // Start-up sequencer after the reset pin rises
    logic [19:0] tmr_q, tmr_d;
    always_comb begin
        run_d = run_q;
        tmr_d = tmr_q + 20'h0_0001;
        case (run_q)
            apc_pkg::RUN_HARD_MUTE: begin
                run_d = apc_pkg::RUN_INIT;
                tmr_d = 20'h0_0000;
            end
            apc_pkg::RUN_INIT: if (tmr_q == INIT_LAST) begin
                run_d = apc_pkg::RUN_START;
                tmr_d = 20'h0_0000;
            end
            apc_pkg::RUN_START: if (tmr_q == START_LAST) begin
                run_d = apc_pkg::RUN_ACTIVE;
            end
            apc_pkg::RUN_ACTIVE: tmr_d = tmr_q;
            default: run_d = apc_pkg::RUN_HARD_MUTE;
        endcase
    end
    always_ff @(posedge mclk) begin
        run_q <= clr ? apc_pkg::RUN_HARD_MUTE : run_d;
        tmr_q <= clr ? 20'h0_0000 : tmr_d;
    end

    // Serial port clocks, output data and direct input five
    logic [7:0]  act_q, act_d;
    logic [1:0]  rate_q, rate_d, mdiv_q, mdiv_d, fmt, wc;
    logic [4:0]  div_q, div_d, half;
    logic [5:0]  bit_q, bit_d, nb, ko, ki;
    logic        bclk_q, bclk_d, lr_q, lr_d, sdo_q, sdo_d;
    logic        master, in5, tick, txld_q, txld_d, i5v_q, i5v_d;
    logic [7:0]  ocfg;
    logic [1:0]  ofmt;
    logic        oin5;
    logic [23:0] txl_q, txl_d, txr_q, txr_d, word;
    logic [23:0] i5sh_q, i5sh_d, i5l_q, i5l_d, i5r_q, i5r_d;
    assign master = act_q[apc_pkg::CFG_MASTER_BIT];
    assign in5 = master & act_q[apc_pkg::CFG_IN5_BIT];
    assign fmt = act_q[1:0];
    assign wc = act_q[3:2];
    assign half = in5 ? (rate_q[1] ? apc_pkg::HALF_192 : apc_pkg::HALF_96) :
                  (rate_q[0] ? apc_pkg::HALF_441 : apc_pkg::HALF_48);
    assign tick = div_q == half - 5'h01;
    assign nb = bit_q + 6'h01;
    assign word = nb[5] ? txr_q : (nb == 6'h00 ? tx_left : txl_q);
    // The first slot of a frame already follows the setting taken there
    assign ocfg = nb == 6'h00 ? cfg_q : act_q;
    assign ofmt = ocfg[1:0];
    assign oin5 = ocfg[apc_pkg::CFG_MASTER_BIT] & ocfg[apc_pkg::CFG_IN5_BIT];
    assign ko = slot_k(ofmt, ocfg[3:2], nb[4:0]);
    assign ki = slot_k(fmt, wc, bit_q[4:0]);
    always_comb begin
        act_d = act_q;
        rate_d = rate_q;
        div_d = div_q + 5'h01;
        bclk_d = bclk_q;
        bit_d = bit_q;
        lr_d = lr_q;
        sdo_d = sdo_q;
        txl_d = txl_q;
        txr_d = txr_q;
        txld_d = 1'b0;
        i5sh_d = i5sh_q;
        i5l_d = i5l_q;
        i5r_d = i5r_q;
        i5v_d = 1'b0;
        mdiv_d = mdiv_q + 2'h1;
        if (!master) begin
            act_d = cfg_q;
            rate_d = {pwc_q[apc_pkg::PWM_I192_BIT], pwc_q[apc_pkg::PWM_F441_BIT]};
            div_d = 5'h00;
            bclk_d = 1'b0;
            lr_d = 1'b0;
            sdo_d = 1'b0;
            bit_d = 6'h3F;
        end else if (tick) begin
            div_d = 5'h00;
            bclk_d = ~bclk_q;
            if (bclk_q) begin
                bit_d = nb;
                lr_d = nb[5] ^ (ofmt != apc_pkg::FMT_I2S);
                sdo_d = ~oin5 & ko[5] &
                        word[apc_pkg::WORD_MSB - ko[4:0]];
                if (nb == 6'h00) begin
                    act_d = cfg_q;
                    rate_d = {pwc_q[apc_pkg::PWM_I192_BIT],
                              pwc_q[apc_pkg::PWM_F441_BIT]};
                    txl_d = tx_left;
                    txr_d = tx_right;
                    txld_d = 1'b1;
                end
            end else if (in5) begin
                if (ki[5]) begin
                    i5sh_d = {i5sh_q[22:0], direct_serial_input_five};
                end
                if (bit_q == 6'h1F) begin
                    i5l_d = i5sh_d << (apc_pkg::WL_24 - wl_bits(wc));
                end
                if (bit_q == 6'h3F) begin
                    i5r_d = i5sh_d << (apc_pkg::WL_24 - wl_bits(wc));
                    i5v_d = 1'b1;
                end
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (clr) begin
            act_q <= apc_pkg::PORT_CFG_RST;
            rate_q <= 2'h0;
            div_q <= 5'h00;
            bclk_q <= 1'b0;
            bit_q <= 6'h3F;
            lr_q <= 1'b0;
            sdo_q <= 1'b0;
            txl_q <= 24'h00_0000;
            txr_q <= 24'h00_0000;
            txld_q <= 1'b0;
            i5sh_q <= 24'h00_0000;
            i5l_q <= 24'h00_0000;
            i5r_q <= 24'h00_0000;
            i5v_q <= 1'b0;
            mdiv_q <= 2'h0;
        end else begin
            act_q <= act_d;
            rate_q <= rate_d;
            div_q <= div_d;
            bclk_q <= bclk_d;
            bit_q <= bit_d;
            lr_q <= lr_d;
            sdo_q <= sdo_d;
            txl_q <= txl_d;
            txr_q <= txr_d;
            txld_q <= txld_d;
            i5sh_q <= i5sh_d;
            i5l_q <= i5l_d;
            i5r_q <= i5r_d;
            i5v_q <= i5v_d;
            mdiv_q <= mdiv_d;
        end
    end
    assign frame_clock_output = lr_q & reset_pin_n;
    assign bit_clock_output = bclk_q & reset_pin_n;
    assign serial_data_output = sdo_q & reset_pin_n;
    assign tx_load = txld_q;
    assign in5_left = i5l_q;
    assign in5_right = i5r_q;
    assign in5_valid = i5v_q;
    // Divide by one passes the input clock straight through
    assign master_clock_output = master & reset_pin_n &
        (act_q[5:4] == 2'h0 ? mclk : act_q[5:4] == 2'h1 ? mdiv_q[0] :
         mdiv_q[1]);
    assign oversample = !in5 ? apc_pkg::OVS_8 :
                        rate_q[1] ? apc_pkg::OVS_2 : apc_pkg::OVS_4;

    // PWM modulators
    logic [7:0] duty_q [8];
    logic [7:0] duty_d [8];
    logic [7:0] pcnt_q, pcnt_d, lim, raw, dsel;
    logic [7:0] pp_q, pp_d, pm_q, pm_d;
    logic [1:0] hpp_q, hpp_d, hpm_q, hpm_d;
    logic       sw, mid, six, on;
    assign six = pwc_q[apc_pkg::PWM_SIX_BIT];
    assign sw = run_q == apc_pkg::RUN_START || run_q == apc_pkg::RUN_ACTIVE;
    assign mid = run_q != apc_pkg::RUN_ACTIVE || mvol_q == apc_pkg::MVOL_MUTE;
    always_comb begin
        case (pwc_q[2:0])
            3'h0: lim = 8'hE0;
            3'h1: lim = 8'hE4;
            3'h2: lim = 8'hE8;
            3'h3: lim = 8'hED;
            3'h4: lim = 8'hF1;
            3'h5: lim = 8'hF5;
            3'h6: lim = 8'hFA;
            default: lim = 8'hFE;
        endcase
    end
    assign raw = {~pcm_data[31], pcm_data[30:24]};
    assign clip_set = pcm_valid & (raw > lim || raw < ~lim);
    always_comb begin
        duty_d = duty_q;
        pcnt_d = pcnt_q + 8'h01;
        if (pcnt_q >= apc_pkg::PWM_TOP - (pwc_q[apc_pkg::PWM_AM_BIT] ?
                {5'h00, am_q[2:0]} : 8'h00)) begin
            pcnt_d = 8'h00;
        end
        if (pcm_valid) begin
            duty_d[pcm_chan] = raw > lim ? lim : raw < ~lim ? ~lim : raw;
        end
        pp_d = 8'h00;
        pm_d = 8'h00;
        hpp_d = 2'h0;
        hpm_d = 2'h0;
        for (int i = 0; i < 8; i++) begin
            dsel = mid ? apc_pkg::DUTY_MID : duty_q[i];
            on = sw & ((i >= 6 && six) ? !pwc_q[apc_pkg::PWM_LOUT_BIT] :
                       !headphone_select_pin);
            pp_d[i] = on & (pcnt_q < dsel);
            pm_d[i] = on & ~(pcnt_q < dsel);
            if (i < 2) begin
                hpp_d[i] = sw & headphone_select_pin & (pcnt_q < dsel);
                hpm_d[i] = sw & headphone_select_pin & ~(pcnt_q < dsel);
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (clr) begin
            duty_q <= '{default: apc_pkg::DUTY_MID};
            pcnt_q <= 8'h00;
            pp_q <= 8'h00;
            pm_q <= 8'h00;
            hpp_q <= 2'h0;
            hpm_q <= 2'h0;
        end else begin
            duty_q <= duty_d;
            pcnt_q <= pcnt_d;
            pp_q <= pp_d;
            pm_q <= pm_d;
            hpp_q <= hpp_d;
            hpm_q <= hpm_d;
        end
    end
    // Gating by the pin forces silence even with no clock running
    assign pwm_p = pp_q & {8{reset_pin_n}};
    assign pwm_m = pm_q & {8{reset_pin_n}};
    assign hp_p = hpp_q & {2{reset_pin_n}};
    assign hp_m = hpm_q & {2{reset_pin_n}};
    assign valid = sw & reset_pin_n;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_pin_rise;
        $rose(reset_pin_n);
    endsequence
    sequence s_start_done;
        run_q == apc_pkg::RUN_START ##1 run_q == apc_pkg::RUN_ACTIVE;
    endsequence
    chk_fmt_legal: assert property (master |-> fmt != 2'h3)
        else $error("illegal output framing");
    chk_word_len: assert property (txld_q |-> wc != 2'h3)
        else $error("illegal word length");
    chk_in5_quiet: assert property (in5 ##1 in5 |-> !sdo_q)
        else $error("data output active with input five");
    chk_frame_64: assert property ($changed(lr_q) && master
        |-> bit_q[4:0] == 5'h00)
        else $error("frame edge not on 32-bit boundary");
    chk_lr_fall: assert property ($changed(lr_q) && master
        |-> $fell(bclk_q))
        else $error("frame clock moved off a falling edge");
    chk_pin_quiet: assert property (!reset_pin_n |-> pwm_p == 8'h00
        && pwm_m == 8'h00 && !valid && sda_drive_n)
        else $error("outputs active under reset pin");
    chk_pin_ignore: assert property (!reset_pin_n |=> i2c_q ==
        apc_pkg::I2C_IDLE && mvol_q == apc_pkg::MVOL_MUTE)
        else $error("bus or volume live under reset pin");
    chk_quiet_start: assert property (s_pin_rise |=>
        run_q == apc_pkg::RUN_INIT ##1 !valid)
        else $error("release skipped initialisation");
    chk_start_valid: assert property (s_start_done |-> valid)
        else $error("valid low after start-up");
    chk_hp_excl: assert property (hp_p != 2'h0 |-> pwm_p[1:0] == 2'h0)
        else $error("headphone and power stage together");
    chk_clip_clear: assert property (wr_en && ptr_q ==
        apc_pkg::REG_ERR_STATUS && !clip_set |=> !clip_q)
        else $error("clip indicator not cleared");
    chk_mute_mid: assert property (mvol_q == apc_pkg::MVOL_MUTE ##1
        pp_q[0] |-> pcnt_q <= apc_pkg::DUTY_MID)
        else $error("channel modulating while muted");
    chk_in5_master: assert property (i5v_q |-> $past(in5))
        else $error("input five taken outside master mode");
endmodule

/* File: apc_src.sv */
`timescale 1ns/1ps
module apc_src (
    input  wire logic        mclk,
    input  wire logic        tx_load,
    input  wire logic        bit_clk,
    input  wire logic        frame_clk,
    output logic [23:0]      tx_left,
    output logic [23:0]      tx_right,
    output logic             in5
);
    localparam logic [23:0] IN5_LEFT  = 24'hA5_0F3C;
    localparam logic [23:0] IN5_RIGHT = 24'h5A_F0C3;
    logic [63:0] frm;
    logic        bclk_q, fclk_q;
    initial begin
        tx_left = 24'h12_3456;
        tx_right = 24'h65_4321;
        in5 = 1'b0;
        frm = 64'h0;
        bclk_q = 1'b0;
        fclk_q = 1'b0;
    end
    // Input five is sent as I2S only: a frame clock fall opens the left slot.
    // Bits move one mclk after a bit clock fall, clear of the rise
    always @(posedge mclk) begin
        bclk_q <= bit_clk;
        fclk_q <= frame_clk;
        if (bclk_q && !bit_clk) begin
            if (fclk_q && !frame_clk) begin
                frm <= {IN5_LEFT, 8'h00, IN5_RIGHT, 8'h00};
                in5 <= 1'b0;
            end else begin
                frm <= {frm[62:0], 1'b0};
                in5 <= frm[63];
            end
        end
        if (tx_load) begin
            tx_left <= tx_left + 24'h00_0001;
            tx_right <= ~tx_right;
        end
    end
endmodule

/* File: audio_port_clocking_pwm_reset_control_test.sv */
`timescale 1ns/1ps
module audio_port_clocking_pwm_reset_control_test;
    logic        mclk = 0, reset = 1, rpin_n = 1, scl = 1, sdah = 1, ack;
    logic        fclk, bclk, sdo, mco, sdn, sdz, vld, hpf, txl, in5;
    logic        hps = 0, pv = 0, i5v;
    logic [23:0] tl, tr, i5l, i5r, w;
    logic [24:0] sw;
    logic [31:0] pd = 32'h0000_0000;
    logic [1:0]  hpp;
    logic [7:0]  pwm_p, r;
    logic [3:0]  ovs;
    logic [15:0] rows [8] = '{16'h013C, 16'h0202, 16'h0380, 16'h040A,
                              16'h05FF, 16'h0603, 16'h0700, 16'h0800};
    int          fails = 0, checked = 0, cyc = 0, bcnt = 0;
    // Open drain: only the low pull of the device overrides the host
    wire         sda_i = sdah & (sdn | sdz);
    always #5 mclk = ~mclk;
    always @(posedge mclk) cyc++;
    always @(posedge bclk) bcnt++;
    apc_src i_src (.mclk(mclk), .tx_load(txl), .bit_clk(bclk),
                   .frame_clk(fclk), .tx_left(tl), .tx_right(tr),
                   .in5(in5));
    apc_top #(.INIT_CYCLES(4), .START_CYCLES(4),
              .IDENT(8'h3C)) // Arbitrary value
    i_dut (.mclk(mclk), .reset(reset), .reset_pin_n(rpin_n), .scl(scl),
        .sda_in(sda_i), .sda_out(sdz), .sda_drive_n(sdn),
        .direct_serial_input_five(in5), .tx_left(tl), .tx_right(tr),
        .tx_load(txl), .frame_clock_output(fclk), .bit_clock_output(bclk),
        .serial_data_output(sdo), .master_clock_output(mco),
        .in5_left(i5l), .in5_right(i5r), .in5_valid(i5v), .pcm_data(pd),
        .pcm_chan(3'h0), .pcm_valid(pv), .headphone_select_pin(hps),
        .pwm_p(pwm_p), .pwm_m(), .hp_p(hpp), .hp_m(), .valid(vld),
        .hpf_enable(hpf), .oversample(ovs));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("BAD %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic sb(input logic b);
        sdah = b;
        idle(4);
        scl = 1;
        idle(2);
        ack = sda_i;
        idle(2);
        scl = 0;
    endtask
    task automatic xb(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            sb(w[i]);
            r[i] = ack;
        end
        sb(1'b1);
    endtask
    task automatic st;
        idle(1);
        sdah = 1;
        scl = 1;
        idle(4);
        sdah = 0;
        idle(4);
        scl = 0;
    endtask
    task automatic sp;
        sdah = 0;
        idle(4);
        scl = 1;
        idle(4);
        sdah = 1;
        idle(4);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e);
        st;
        xb(8'h36);
        chk(ack, e);
        xb(a);
        xb(d);
        sp;
    endtask
    task automatic rd(input logic [7:0] a);
        st;
        xb(8'h36);
        xb(a);
        sp;
        st;
        xb(8'h37);
        xb(8'hFF);
        sp;
    endtask
    // Skip one frame so a new setting has reached the frame boundary
    task automatic fr(input int p);
        int c0, b0;
        @(posedge fclk);
        @(posedge fclk);
        c0 = cyc;
        b0 = bcnt;
        @(posedge fclk);
        chk(cyc - c0, p);
        chk(bcnt - b0, 64);
    endtask
    task final_report;
        $display("fails %0d checked %0d", fails, checked);
        if (fails == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        int c0;
        fork
            begin
                #400_000;
                fails++;
                final_report;
            end
        join_none
        idle(16);
        reset = 0;
        idle(20);
        foreach (rows[i]) begin
            rd(rows[i][15:8]);
            chk(r, rows[i][7:0]);
        end
        chk(ovs, apc_pkg::OVS_8);
        pd = 32'h7F00_0000;
        pv = 1;
        idle(1);
        pv = 0;
        rd(8'h02);
        chk(r, 8'h03);
        wr(8'h02, 8'h00, 1'b0);
        rd(8'h02);
        chk(r, 8'h02);
        wr(8'h04, 8'h6A, 1'b0);
        fr(2048);
        @(posedge mco);
        c0 = cyc;
        @(posedge mco);
        chk(cyc - c0, 4);
        @(posedge txl) w = tl;
        repeat (25) @(posedge bclk) sw = {sw[23:0], sdo};
        chk(sw[23:0], w);
        wr(8'h04, 8'hEA, 1'b0);
        fr(1024);
        chk(sdo, 0);
        @(posedge i5v) idle(1);
        chk(i5l, 24'hA5_0F3C);
        chk(i5r, 24'h5A_F0C3);
        wr(8'h03, 8'h00, 1'b0);
        chk(hpf, 0);
        hps = 1;
        wr(8'h07, 8'h07, 1'b0);
        wr(8'h06, 8'hCB, 1'b0);
        fr(512);
        chk(ovs, apc_pkg::OVS_2);
        @(posedge hpp[0]) c0 = cyc;
        @(posedge hpp[0]) chk(cyc - c0, 249);
        idle(1);
        chk({pwm_p, hpp}, 10'h303);
        hps = 0;
        wr(8'h05, 8'hFF, 1'b0);
        rpin_n = 0;
        idle(1);
        chk({pwm_p, vld, sdn, fclk, bclk}, 12'h004);
        wr(8'h03, 8'h80, 1'b1);
        rpin_n = 1;
        idle(20);
        chk({hpf, vld, ovs}, {2'b11, apc_pkg::OVS_8});
        final_report;
    end
endmodule
